// [port_sel_pkg.sv]
// shared constants for the port select, pin status and edge counter bank
// assumes an i2c slave front end that decodes a byte address per access
package port_sel_pkg;
	localparam logic [7:0] ADDR_PIN_STATUS_LOW  = 8'h1C;
	localparam logic [7:0] ADDR_PIN_STATUS_HIGH = 8'h1D;
	localparam logic [7:0] ADDR_PORT_SELECT     = 8'h1E;
	localparam logic [7:0] ADDR_EDGE_COUNTER    = 8'h1F;
	localparam logic [7:0] PORT_SELECT_RESET    = 8'h01;
	localparam logic [7:0] EDGE_COUNT_MAX       = 8'hFF;
	localparam logic [7:0] ZERO_BYTE            = 8'h00;
	localparam int         BIT_FIRST_SEL        = 0;
	localparam int         BIT_SECOND_SEL       = 1;
	localparam int         BIT_SEC_ADDR_EN      = 2;
	localparam logic [6:0] SECONDARY_ADDR_STEP  = 7'h01;
	localparam int         OSC_PERIOD_NS        = 40;
	localparam int         CORE_PERIOD_NS       = 5;
	// last core cycle of one oscillator period; the divider counts 0 up to this
	localparam logic [2:0] OSC_DIV_LAST         = 3'(OSC_PERIOD_NS / CORE_PERIOD_NS - 1);
endpackage

// [port_select_bank.sv]
// port select, pin status and pixel clock edge counter registers
// assumes an i2c slave delivers one-cycle read/write strobes with the matched
// slave address; one window tick is one oscillator period, made from core_clk
`timescale 1ns/1ps
module port_select_bank (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic [6:0] primary_slave_address,
	input  wire logic [6:0] i2c_addr,
	input  wire logic       i2c_wr,
	input  wire logic       i2c_rd,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] wr_data,
	input  wire logic [7:0] local_pins,
	input  wire logic [3:0] second_port_pins,
	input  wire logic       aux_pin_eight,
	input  wire logic       pixel_clk,
	output logic            addr_match,
	output logic            wr_first_port,
	output logic            wr_second_port,
	output logic            wr_shared,
	output logic            rd_second_port,
	output logic [7:0]      rd_data
);
	logic       secondary_address_enable;
	logic       second_port_select;
	logic       first_port_select;
	logic [7:0] port_sel, next_port_sel;
	logic [7:0] edge_count, next_edge_count;
	logic [7:0] window_left, next_window_left;
	logic [2:0] osc_div, next_osc_div;
	logic       osc_tick;
	logic [7:0] next_rd_data;
	logic       pix_s1, pix_s2, pix_s3;
	logic       at_primary, at_secondary, pix_rise;
	logic [6:0] secondary_addr;

	assign secondary_address_enable = port_sel[port_sel_pkg::BIT_SEC_ADDR_EN];
	assign second_port_select       = port_sel[port_sel_pkg::BIT_SECOND_SEL];
	assign first_port_select        = port_sel[port_sel_pkg::BIT_FIRST_SEL];

	// address decode; secondary only when enabled
	assign secondary_addr = primary_slave_address + port_sel_pkg::SECONDARY_ADDR_STEP;
	assign at_primary     = (i2c_addr == primary_slave_address);
	assign at_secondary   = secondary_address_enable && (i2c_addr == secondary_addr);
	assign addr_match     = at_primary || at_secondary;

	// port steering; secondary enable overrides both selects
	always_comb begin
		wr_first_port  = 1'b0;
		wr_second_port = 1'b0;
		wr_shared      = 1'b0;
		rd_second_port = 1'b0;
		if (at_secondary) begin
			wr_second_port = i2c_wr;
			wr_shared      = i2c_wr;
			rd_second_port = 1'b1;
		end else if (at_primary && secondary_address_enable) begin
			wr_first_port  = i2c_wr; // selects ignored
			wr_shared      = i2c_wr;
		end else if (at_primary) begin
			wr_second_port = i2c_wr && second_port_select;
			wr_first_port  = i2c_wr && first_port_select;
			wr_shared      = i2c_wr && (first_port_select || second_port_select);
			rd_second_port = second_port_select;
		end
	end

	// pixel clock into core domain; first stage read only by second
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pix_s1 <= 1'b0;
			pix_s2 <= 1'b0;
			pix_s3 <= 1'b0;
		end else begin
			pix_s1 <= pixel_clk;
			pix_s2 <= pix_s1;
			pix_s3 <= pix_s2;
		end
	end
	// limitation: pixel clock above core_clk/2 undercounts
	assign pix_rise = pix_s2 && !pix_s3;

	// oscillator period made from core cycles; window only shrinks on this tick
	assign osc_tick = (osc_div == port_sel_pkg::OSC_DIV_LAST);

	// register writes and edge counter window
	always_comb begin
		next_port_sel    = port_sel;
		next_edge_count  = edge_count;
		next_window_left = window_left;
		next_osc_div     = osc_div;
		if (window_left != port_sel_pkg::ZERO_BYTE) begin
			next_osc_div = osc_tick ? 3'h0 : osc_div + 3'h1;
			if (osc_tick)
				next_window_left = window_left - 8'h01;
			if (pix_rise && edge_count != port_sel_pkg::EDGE_COUNT_MAX)
				next_edge_count = edge_count + 8'h01;
		end
		if (addr_match && i2c_wr) begin
			if (reg_addr == port_sel_pkg::ADDR_PORT_SELECT)
				next_port_sel = {5'h00, wr_data[2:0]};
			if (reg_addr == port_sel_pkg::ADDR_EDGE_COUNTER) begin
				next_edge_count  = port_sel_pkg::ZERO_BYTE;
				next_window_left = wr_data;
				next_osc_div     = 3'h0; // restart divider so a window is whole ticks
			end
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			port_sel    <= port_sel_pkg::PORT_SELECT_RESET;
			edge_count  <= 8'h00;
			window_left <= 8'h00;
			osc_div     <= 3'h0;
		end else begin
			port_sel    <= next_port_sel;
			edge_count  <= next_edge_count;
			window_left <= next_window_left;
			osc_div     <= next_osc_div;
		end
	end

	// read data, registered one cycle after the read strobe
	always_comb begin
		next_rd_data = rd_data;
		if (addr_match && i2c_rd) begin
			unique case (reg_addr)
				port_sel_pkg::ADDR_PIN_STATUS_LOW: begin
					next_rd_data = {local_pins[7:5], 1'b0,
						rd_second_port ? second_port_pins : local_pins[3:0]};
				end
				port_sel_pkg::ADDR_PIN_STATUS_HIGH: next_rd_data = {7'h00, aux_pin_eight};
				port_sel_pkg::ADDR_PORT_SELECT:     next_rd_data = port_sel;
				port_sel_pkg::ADDR_EDGE_COUNTER:    next_rd_data = edge_count;
				default:                            next_rd_data = port_sel_pkg::ZERO_BYTE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			rd_data <= 8'h00;
		else
			rd_data <= next_rd_data;
	end

	// checks
	property p_sat;
		@(posedge core_clk) disable iff (!resetn)
		edge_count == 8'hFF && !(addr_match && i2c_wr) |=> edge_count == 8'hFF;
	endproperty
	a_sat: assert property (p_sat) else $error("edge count wrapped");

	property p_clear;
		@(posedge core_clk) disable iff (!resetn)
		addr_match && i2c_wr && reg_addr == port_sel_pkg::ADDR_EDGE_COUNTER
		|=> edge_count == 8'h00 && window_left == $past(wr_data);
	endproperty
	a_clear: assert property (p_clear) else $error("counter write did not restart");

	property p_freeze;
		@(posedge core_clk) disable iff (!resetn)
		window_left == 8'h00 && !(addr_match && i2c_wr) |=> $stable(edge_count);
	endproperty
	a_freeze: assert property (p_freeze) else $error("count moved outside window");

	property p_window;
		@(posedge core_clk) disable iff (!resetn)
		window_left != port_sel_pkg::ZERO_BYTE && osc_tick && !(addr_match && i2c_wr)
		|=> window_left == $past(window_left) - 8'h01;
	endproperty
	a_window: assert property (p_window) else $error("window did not shrink on tick");

	property p_hold;
		@(posedge core_clk) disable iff (!resetn)
		!osc_tick && !(addr_match && i2c_wr) |=> $stable(window_left);
	endproperty
	a_hold: assert property (p_hold) else $error("window moved between ticks");

	// first tick of a fresh window comes eight core cycles after the write
	property p_tick;
		@(posedge core_clk) disable iff (!resetn)
		addr_match && i2c_wr && reg_addr == port_sel_pkg::ADDR_EDGE_COUNTER
		&& wr_data != port_sel_pkg::ZERO_BYTE ##1 !(addr_match && i2c_wr) [*7] |=> osc_tick;
	endproperty
	a_tick: assert property (p_tick) else $error("oscillator tick spacing wrong");

	property p_sec_addr;
		@(posedge core_clk) disable iff (!resetn)
		i2c_addr == secondary_addr && !at_primary |-> addr_match == secondary_address_enable;
	endproperty
	a_sec_addr: assert property (p_sec_addr) else $error("secondary address decode wrong");

	property p_override;
		@(posedge core_clk) disable iff (!resetn)
		at_primary && !at_secondary && secondary_address_enable |-> !rd_second_port;
	endproperty
	a_override: assert property (p_override) else $error("selects not ignored");

	property p_wr2;
		@(posedge core_clk) disable iff (!resetn)
		at_primary && !secondary_address_enable && second_port_select && i2c_wr |-> wr_second_port && wr_shared;
	endproperty
	a_wr2: assert property (p_wr2) else $error("second port write missed");

	property p_wr1;
		@(posedge core_clk) disable iff (!resetn)
		at_primary && !secondary_address_enable && first_port_select && i2c_wr |-> wr_first_port && wr_shared;
	endproperty
	a_wr1: assert property (p_wr1) else $error("first port write missed");

	property p_high;
		@(posedge core_clk) disable iff (!resetn)
		addr_match && i2c_rd && reg_addr == port_sel_pkg::ADDR_PIN_STATUS_HIGH |=> rd_data[7:1] == 7'h00;
	endproperty
	a_high: assert property (p_high) else $error("reserved bits nonzero");

	property p_cnt_rd;
		@(posedge core_clk) disable iff (!resetn)
		addr_match && i2c_rd && reg_addr == port_sel_pkg::ADDR_EDGE_COUNTER |=> rd_data == $past(edge_count);
	endproperty
	a_cnt_rd: assert property (p_cnt_rd) else $error("counter read wrong");

	property p_remote;
		@(posedge core_clk) disable iff (!resetn)
		at_primary && !secondary_address_enable && second_port_select && i2c_rd
		&& reg_addr == port_sel_pkg::ADDR_PIN_STATUS_LOW |=> rd_data[3:0] == $past(second_port_pins);
	endproperty
	a_remote: assert property (p_remote) else $error("second port pins not shown");
endmodule

// [host_model.sv]
// host side: issues one-cycle register strobes toward the bank
// assumes core_clk runs and the bench calls access from one process
`timescale 1ns/1ps
module host_model (
	input  wire logic       core_clk,
	output logic [6:0]      i2c_addr,
	output logic            i2c_wr,
	output logic            i2c_rd,
	output logic [7:0]      reg_addr,
	output logic [7:0]      wr_data
);
	initial begin
		i2c_addr = 7'h00;
		i2c_wr = 1'b0;
		i2c_rd = 1'b0;
		reg_addr = 8'h00;
		wr_data = 8'h00;
	end
	// drive at the fall, taken at the rise; released reg_addr and wr_data show the inverse, not stale data, and i2c_addr keeps its value
	task automatic access(input logic [6:0] a, input logic w, input logic [7:0] r, input logic [7:0] d);
		@(negedge core_clk);
		i2c_addr = a;
		i2c_wr = w;
		i2c_rd = !w;
		reg_addr = r;
		wr_data = d;
		@(negedge core_clk);
		i2c_wr = 1'b0;
		i2c_rd = 1'b0;
		reg_addr = ~r;
		wr_data = ~d;
	endtask
endmodule

// [testbench.sv]
// self-checking bench: register accesses through the host model, counter windows
// assumes the bank samples pixel_clk with core_clk and eight core cycles per window tick
`timescale 1ns/1ps
module testbench;
	localparam logic [6:0] PRI = 7'h2C;
	logic       core_clk, resetn, aux_pin_eight, pixel_clk, addr_match;
	logic       wr_first_port, wr_second_port, wr_shared, rd_second_port, i2c_wr, i2c_rd;
	logic [6:0] i2c_addr;
	logic [7:0] reg_addr, wr_data, local_pins, rd_data;
	logic [3:0] second_port_pins, steer, rsteer;
	int         n_mismatch, compares, pix_div;
	initial core_clk = 1'b0;
	always #2.5 core_clk = ~core_clk;
	host_model host (.core_clk(core_clk), .i2c_addr(i2c_addr), .i2c_wr(i2c_wr), .i2c_rd(i2c_rd),
		.reg_addr(reg_addr), .wr_data(wr_data));
	port_select_bank dut (.core_clk(core_clk), .resetn(resetn), .primary_slave_address(PRI),
		.i2c_addr(i2c_addr), .i2c_wr(i2c_wr), .i2c_rd(i2c_rd), .reg_addr(reg_addr),
		.wr_data(wr_data), .local_pins(local_pins), .second_port_pins(second_port_pins),
		.aux_pin_eight(aux_pin_eight), .pixel_clk(pixel_clk), .addr_match(addr_match),
		.wr_first_port(wr_first_port), .wr_second_port(wr_second_port), .wr_shared(wr_shared),
		.rd_second_port(rd_second_port), .rd_data(rd_data));
	// pixel clock of four core cycles, slow enough for the sampler to see every rise
	always @(negedge core_clk) begin
		pix_div <= pix_div + 1;
		if (pix_div % 2 == 1) pixel_clk <= ~pixel_clk;
	end
	// steering is combinational, so catch it at the edge that takes the strobe
	always @(posedge core_clk) begin
		if (i2c_wr) steer <= {addr_match, wr_first_port, wr_second_port, wr_shared};
		if (i2c_rd) rsteer <= {addr_match, rd_second_port, 2'b00};
	end
	task automatic chk(input string what, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] got);
		compares++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			n_mismatch++;
			$display("[ERR] %s expected %h..%h seen %h", what, lo, hi, got);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d, input logic [3:0] s);
		host.access(a, 1'b1, r, d);
		chk("steer", {4'h0, s}, {4'h0, s}, {4'h0, steer});
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] r, input logic [7:0] lo, input logic [7:0] hi);
		host.access(a, 1'b0, r, 8'h00);
		chk("rd_data", lo, hi, rd_data);
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// tests need about 2000 core cycles; twice that is a hang
	initial begin
		#20000;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		{resetn, pixel_clk, pix_div, n_mismatch, compares} = '0;
		{aux_pin_eight, local_pins, second_port_pins} = {1'b1, 8'hB5, 4'h6};
		repeat (8) @(negedge core_clk);
		resetn = 1'b1;
		rd(PRI, port_sel_pkg::ADDR_PORT_SELECT, 8'h01, 8'h01);
		rd(PRI, port_sel_pkg::ADDR_EDGE_COUNTER, 8'h00, 8'h00);
		rd(PRI, port_sel_pkg::ADDR_PIN_STATUS_LOW, 8'hA5, 8'hA5);
		rd(PRI, port_sel_pkg::ADDR_PIN_STATUS_HIGH, 8'h01, 8'h01);
		aux_pin_eight = 1'b0;
		rd(PRI, port_sel_pkg::ADDR_PIN_STATUS_HIGH, 8'h00, 8'h00);
		wr(PRI, port_sel_pkg::ADDR_PORT_SELECT, 8'h02, 4'hD);
		wr(PRI, port_sel_pkg::ADDR_PIN_STATUS_LOW, 8'hFF, 4'hB);
		rd(PRI, port_sel_pkg::ADDR_PIN_STATUS_LOW, 8'hA6, 8'hA6);
		chk("rsteer", 8'h0C, 8'h0C, {4'h0, rsteer});
		wr(PRI, port_sel_pkg::ADDR_PORT_SELECT, 8'h03, 4'hB);
		rd(PRI, port_sel_pkg::ADDR_PIN_STATUS_LOW, 8'hA6, 8'hA6);
		// host enables the second address before any access at it
		wr(PRI, port_sel_pkg::ADDR_PORT_SELECT, 8'hFF, 4'hF);
		rd(PRI, port_sel_pkg::ADDR_PORT_SELECT, 8'h07, 8'h07);
		rd(PRI + 7'h01, port_sel_pkg::ADDR_PIN_STATUS_LOW, 8'hA6, 8'hA6);
		wr(PRI, port_sel_pkg::ADDR_PIN_STATUS_LOW, 8'h00, 4'hD);
		wr(PRI + 7'h01, port_sel_pkg::ADDR_PIN_STATUS_LOW, 8'h00, 4'hB);
		// second select and secondary enable cleared before accesses at the second address go unmatched
		wr(PRI, port_sel_pkg::ADDR_PORT_SELECT, 8'h01, 4'hD);
		rd(PRI, port_sel_pkg::ADDR_PORT_SELECT, 8'h01, 8'h01);
		wr(PRI + 7'h01, port_sel_pkg::ADDR_PIN_STATUS_LOW, 8'h00, 4'h0);
		// unmatched read must leave the last answer standing
		rd(PRI + 7'h01, port_sel_pkg::ADDR_PIN_STATUS_LOW, 8'h01, 8'h01);
		wr(PRI, port_sel_pkg::ADDR_EDGE_COUNTER, 8'd40, 4'hD);
		// 40 ticks of 8 core cycles, a pixel rise every 4 core cycles
		repeat (330) @(negedge core_clk);
		rd(PRI, port_sel_pkg::ADDR_EDGE_COUNTER, 8'd79, 8'd81);
		repeat (20) @(negedge core_clk);
		rd(PRI, port_sel_pkg::ADDR_EDGE_COUNTER, 8'd79, 8'd81);
		wr(PRI, port_sel_pkg::ADDR_EDGE_COUNTER, 8'd200, 4'hD);
		rd(PRI, port_sel_pkg::ADDR_EDGE_COUNTER, 8'd0, 8'd1);
		// 1600 core cycles would give 400 rises, far past the count limit
		repeat (1610) @(negedge core_clk);
		rd(PRI, port_sel_pkg::ADDR_EDGE_COUNTER, 8'hFF, 8'hFF);
		tally_and_finish();
	end
endmodule
